// *** src/spi_pin_baud_ctrl.sv ***
/*
 SPI pin-mode and bit-rate control: APB registers, pad steering for
 select and data pins, wait-mode clock gating and the bit-rate divider.
 Assumes the shifter and status logic sit outside and use the pad
 control, bit tick and clock run outputs.
*/
`include "spi_pin_baud_regs.svh"

module spi_pin_baud_ctrl (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // System state
   input wire logic i_wait_mode,
   // Shifter side
   input wire logic i_ser_out,
   input wire logic i_sel_out,
   output logic o_ser_in,
   output logic o_sel_in_n,
   output logic o_mode_fault_in_n,
   output logic o_clk_run,
   output logic o_bit_tick,
   output logic o_bit_clk,
   output logic o_controller_select,
   // Controller-out/target-in pad
   input wire logic i_cotin_pad,
   output logic o_cotin_out,
   output logic o_cotin_oe_n,
   output logic o_cotin_spi,
   // Controller-in/target-out pad
   input wire logic i_citout_pad,
   output logic o_citout_out,
   output logic o_citout_oe_n,
   output logic o_citout_spi,
   // Slave-select pad
   input wire logic i_sel_pad,
   output logic o_sel_out,
   output logic o_sel_oe_n,
   output logic o_sel_spi
);
   logic [7:0] ctrl_two_reg;
   logic [7:0] bit_rate_reg;
   logic [7:0] mode_ctrl_reg;
   logic [2:0] sel_sync_reg;
   logic [2:0] cotin_sync_reg;
   logic [2:0] citout_sync_reg;
   logic sel_clean_reg;
   logic cotin_clean_reg;
   logic citout_clean_reg;
   spi_pin_baud_pkg::sel_role_t sel_role;
   spi_pin_baud_pkg::pad_ctrl_t cotin_pad;
   spi_pin_baud_pkg::pad_ctrl_t citout_pad;
   spi_pin_baud_pkg::pad_ctrl_t sel_pad;
   spi_pin_baud_pkg::rate_cfg_t rate_cfg;
   logic [7:0] rd_byte;
   logic pre_tick;

   // APB decode; every access finishes in its first access cycle
   wire wr_en = i_psel & i_penable & i_pwrite;
   wire hit_ct = (i_paddr == `CTRL_TWO_OFFSET);
   wire hit_br = (i_paddr == `BIT_RATE_OFFSET);
   wire hit_mc = (i_paddr == `MODE_CTRL_OFFSET);
   wire hit_ps = (i_paddr == `PIN_STATUS_OFFSET);
   wire mapped = hit_ct | hit_br | hit_mc | hit_ps;
   wire lane0 = i_pstrb[0];
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel & i_penable & ~mapped;

   // Named control bits
   wire controller = mode_ctrl_reg[`MC_CONTROLLER_BIT];
   wire sel_drive_en = mode_ctrl_reg[`MC_SEL_DRIVE_BIT];
   wire fault_detect_enable = ctrl_two_reg[`CT_FAULT_EN_BIT];
   wire shared_pin_drive_enable = ctrl_two_reg[`CT_SHARED_OE_BIT];
   wire halt_in_wait = ctrl_two_reg[`CT_HALT_WAIT_BIT];
   wire single_wire_select = ctrl_two_reg[`CT_SINGLE_WIRE_BIT];
   assign o_controller_select = controller;

   // Register writes; byte lane 0 only, masks keep empty bits at zero
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_two_reg <= `CTRL_TWO_RESET;
         bit_rate_reg <= `BIT_RATE_RESET;
         mode_ctrl_reg <= `MODE_CTRL_RESET;
      end else if (wr_en && lane0) begin
         if (hit_ct) ctrl_two_reg <= i_pwdata[7:0] & `CT_WRITE_MASK;
         if (hit_br) bit_rate_reg <= i_pwdata[7:0] & `BR_WRITE_MASK;
         if (hit_mc) mode_ctrl_reg <= i_pwdata[7:0] & `MC_WRITE_MASK;
      end
   end

   // Read mux; status word shows cleaned pad levels and the select role
   assign rd_byte = hit_ct ? (ctrl_two_reg & `CT_WRITE_MASK) :
      hit_br ? (bit_rate_reg & `BR_WRITE_MASK) :
      hit_mc ? mode_ctrl_reg :
      hit_ps ? {3'h0, sel_role, citout_clean_reg, cotin_clean_reg, sel_clean_reg} :
      8'h00;

   // Read data registered at the setup cycle so it stands in the access cycle
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= {24'h00_0000, rd_byte};
      end
   end

   // Pad inputs pass three flops; a change counts once the last two agree
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sel_sync_reg <= 3'b111;
         cotin_sync_reg <= 3'b000;
         citout_sync_reg <= 3'b000;
      end else begin
         sel_sync_reg <= {sel_sync_reg[1:0], i_sel_pad};
         cotin_sync_reg <= {cotin_sync_reg[1:0], i_cotin_pad};
         citout_sync_reg <= {citout_sync_reg[1:0], i_citout_pad};
      end
   end

   // Agreement filter on stages two and three only
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sel_clean_reg <= 1'b1;
         cotin_clean_reg <= 1'b0;
         citout_clean_reg <= 1'b0;
      end else begin
         if (sel_sync_reg[1] == sel_sync_reg[2]) sel_clean_reg <= sel_sync_reg[2];
         if (cotin_sync_reg[1] == cotin_sync_reg[2]) cotin_clean_reg <= cotin_sync_reg[2];
         if (citout_sync_reg[1] == citout_sync_reg[2]) citout_clean_reg <= citout_sync_reg[2];
      end
   end

   // Select pin role; target ignores the fault enable
   assign sel_role = !controller ? spi_pin_baud_pkg::SEL_TARGET_IN :
      !fault_detect_enable ? spi_pin_baud_pkg::SEL_RELEASED :
      sel_drive_en ? spi_pin_baud_pkg::SEL_DRIVE_OUT :
      spi_pin_baud_pkg::SEL_FAULT_IN;

   // Select pad steering; released pin stays undriven and unsampled
   assign sel_pad.spi_owned = (sel_role != spi_pin_baud_pkg::SEL_RELEASED);
   assign sel_pad.oe_n = (sel_role != spi_pin_baud_pkg::SEL_DRIVE_OUT);
   assign sel_pad.out = i_sel_out;
   assign o_sel_in_n = (sel_role == spi_pin_baud_pkg::SEL_TARGET_IN) ? sel_clean_reg : 1'b1;
   assign o_mode_fault_in_n =
      (sel_role == spi_pin_baud_pkg::SEL_FAULT_IN) ? sel_clean_reg : 1'b1;

   // Data pads: four-wire roles, or one shared pin per role in single wire
   wire use_cotin = !single_wire_select | controller;
   wire use_citout = !single_wire_select | !controller;
   wire shared_drive = single_wire_select & shared_pin_drive_enable;
   assign cotin_pad.spi_owned = use_cotin;
   assign cotin_pad.oe_n = single_wire_select ? !(controller & shared_drive) : !controller;
   assign cotin_pad.out = i_ser_out;
   assign citout_pad.spi_owned = use_citout;
   assign citout_pad.oe_n = single_wire_select ? !(!controller & shared_drive) : controller;
   assign citout_pad.out = i_ser_out;

   // Serial input pin: shared pin in single wire, else the role's input pad
   assign o_ser_in = single_wire_select ? (controller ? cotin_clean_reg : citout_clean_reg) :
      (controller ? citout_clean_reg : cotin_clean_reg);

   // Pad outputs; data levels come from the registered shifter side
   assign o_cotin_out = cotin_pad.out;
   assign o_cotin_oe_n = cotin_pad.oe_n;
   assign o_cotin_spi = cotin_pad.spi_owned;
   assign o_citout_out = citout_pad.out;
   assign o_citout_oe_n = citout_pad.oe_n;
   assign o_citout_spi = citout_pad.spi_owned;
   assign o_sel_out = sel_pad.out;
   assign o_sel_oe_n = sel_pad.oe_n;
   assign o_sel_spi = sel_pad.spi_owned;

   // Clock run enable: stopping in wait also freezes the divider
   assign o_clk_run = !(halt_in_wait & i_wait_mode);

   // Live fields: a rate change mid-transfer applies at once to the running counts
   assign rate_cfg.prescale_select = bit_rate_reg[`BR_PRESCALE_LSB +: 3];
   assign rate_cfg.rate_divisor_select = bit_rate_reg[`BR_RATE_LSB +: 3];

   // Prescale stage
   spi_prescaler u_prescaler (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_run(o_clk_run & controller),
      .i_prescale_select(rate_cfg.prescale_select),
      .o_tick(pre_tick)
   );

   // Rate divider stage feeding the bit clock
   spi_rate_divider u_rate_divider (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_tick(pre_tick),
      .i_rate_divisor_select(rate_cfg.rate_divisor_select),
      .o_bit_tick(o_bit_tick),
      .o_bit_clk(o_bit_clk)
   );

   // Checks
   property read_zero_p;
      @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_psel && !i_penable && !i_pwrite && hit_ct) |=> (o_prdata[7:5] == 3'h0 && !o_prdata[2]);
   endproperty
   ctrl_two_zero_a: assert property (read_zero_p)
      else $error("empty control-two bits read nonzero");

   rate_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (i_psel && !i_penable && !i_pwrite && hit_br) |=> (o_prdata[7] == 1'b0 && !o_prdata[3]))
      else $error("empty bit-rate bits read nonzero");

   target_sel_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      !controller |-> (o_sel_oe_n && o_sel_spi && o_mode_fault_in_n))
      else $error("target mode misused select pin");

   released_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (controller && !fault_detect_enable) |-> (!o_sel_spi && o_sel_oe_n && o_sel_in_n))
      else $error("select pin not released");

   sel_drive_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (controller && fault_detect_enable) |-> (o_sel_spi && (o_sel_oe_n == !sel_drive_en)))
      else $error("select pin role wrong with fault detect on");

   sequence fault_low_s;
      sel_role == spi_pin_baud_pkg::SEL_FAULT_IN && !i_sel_pad;
   endsequence
   fault_path_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (fault_low_s [*5]) |-> !o_mode_fault_in_n)
      else $error("fault input did not follow pad");

   shared_oe_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      single_wire_select |-> ((controller ? o_cotin_oe_n : o_citout_oe_n) == !shared_pin_drive_enable)
      && (controller ? !o_citout_spi : !o_cotin_spi))
      else $error("shared pin drive wrong");

   four_wire_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      !single_wire_select |-> (o_cotin_oe_n == !controller && o_citout_oe_n == controller))
      else $error("four-wire drivers wrong");

   wait_halt_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (halt_in_wait && i_wait_mode) |-> (!o_clk_run && !o_bit_tick))
      else $error("clocks ran in wait with halt set");

   rate_write_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (wr_en && lane0 && hit_br) |=> (bit_rate_reg == ($past(i_pwdata[7:0]) & `BR_WRITE_MASK)))
      else $error("bit-rate write lost");

   no_tick_target_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (!controller && $past(!controller)) |-> !pre_tick)
      else $error("bit rate ran in target mode");
endmodule : spi_pin_baud_ctrl

// *** src/spi_pin_baud_pkg.sv ***
/*
 Types of the SPI pin-mode and bit-rate block. Assumes the constants
 header is compiled alongside.
*/
package spi_pin_baud_pkg;

   // Pin roles of the slave-select pin
   typedef enum logic [1:0] {
      SEL_TARGET_IN = 2'b00,
      SEL_RELEASED = 2'b01,
      SEL_FAULT_IN = 2'b11,
      SEL_DRIVE_OUT = 2'b10
   } sel_role_t;

   // Output enables and levels toward one pad
   typedef struct packed {
      logic out;
      logic oe_n;
      logic spi_owned;
   } pad_ctrl_t;

   // Settings handed to the divider
   typedef struct packed {
      logic [2:0] prescale_select;
      logic [2:0] rate_divisor_select;
   } rate_cfg_t;

endpackage : spi_pin_baud_pkg

// *** src/spi_pin_baud_regs.svh ***
/*
 Register offsets, field positions and reset values of the
 SPI pin-mode and bit-rate control block. Assumes an APB slave with
 32-bit data, one aligned word per register.
*/
`ifndef SPI_PIN_BAUD_REGS_SVH
`define SPI_PIN_BAUD_REGS_SVH

// Register byte addresses
`define CTRL_TWO_OFFSET 12'h000
`define BIT_RATE_OFFSET 12'h004
`define MODE_CTRL_OFFSET 12'h008
`define PIN_STATUS_OFFSET 12'h00c

// Control-two field positions
`define CT_FAULT_EN_BIT 4
`define CT_SHARED_OE_BIT 3
`define CT_HALT_WAIT_BIT 1
`define CT_SINGLE_WIRE_BIT 0
`define CT_WRITE_MASK 8'h1b

// Bit-rate field positions
`define BR_PRESCALE_LSB 4
`define BR_RATE_LSB 0
`define BR_WRITE_MASK 8'h77

// Mode-control field positions
`define MC_CONTROLLER_BIT 0
`define MC_SEL_DRIVE_BIT 1
`define MC_WRITE_MASK 8'h03

// Reset values
`define CTRL_TWO_RESET 8'h00
`define BIT_RATE_RESET 8'h00
`define MODE_CTRL_RESET 8'h00

`endif

// *** src/spi_prescaler.sv ***
/*
 Prescale stage: one enable pulse every prescale_select+1 cycles.
 Assumes one core clock and an active low asynchronous reset.
*/
module spi_prescaler (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Control
   input wire logic i_run,
   input wire logic [2:0] i_prescale_select,
   // Output
   output logic o_tick
);
   logic [2:0] count_reg;
   logic [2:0] count_next;
   wire at_end = (count_reg >= i_prescale_select); // Tolerates live changes

   // Count wraps at field value, so divisor is field plus one
   assign count_next = at_end ? 3'h0 : count_reg + 3'h1;
   assign o_tick = i_run & at_end;

   // Holds while stopped
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_reg <= 3'h0;
      end else if (i_run) begin
         count_reg <= count_next;
      end
   end

   prescale_period_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (o_tick && $stable(i_prescale_select) && i_prescale_select == 3'h1 && i_run) |=>
      (!o_tick || !i_run || !$stable(i_prescale_select)))
      else $error("prescaler ticked twice in a row at divisor two");
endmodule : spi_prescaler

// *** src/spi_rate_divider.sv ***
/*
 Rate divider: halves its input tick rate 1 to 8 times, giving divisors
 2 to 256. Output toggles a bit clock and pulses once per bit period.
*/
module spi_rate_divider (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // Control
   input wire logic i_tick,
   input wire logic [2:0] i_rate_divisor_select,
   // Output
   output logic o_bit_tick,
   output logic o_bit_clk
);
   logic [7:0] count_reg;
   logic bit_clk_reg;
   logic [7:0] limit;
   wire at_end;

   // Limit of 2^(n+1)-1 ticks per bit period
   // Shift amount widened so code seven reaches 256 instead of wrapping
   assign limit = 8'(({1'b0, 8'h01} << ({1'b0, i_rate_divisor_select} + 4'h1)) - 9'h001);
   assign at_end = i_tick & (count_reg >= limit);
   assign o_bit_tick = at_end;
   assign o_bit_clk = bit_clk_reg;

   // Half-period toggle at mid count gives a square bit clock
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_reg <= 8'h00;
         bit_clk_reg <= 1'b0;
      end else if (i_tick) begin
         count_reg <= at_end ? 8'h00 : count_reg + 8'h01;
         if (at_end || count_reg == (limit >> 1)) begin
            bit_clk_reg <= ~bit_clk_reg;
         end
      end
   end

   div_two_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (o_bit_tick && i_rate_divisor_select == 3'h0 && $stable(i_rate_divisor_select)) |=>
      !o_bit_tick)
      else $error("rate divider gave two bit ticks back to back");
endmodule : spi_rate_divider

// *** tb/spi_far_end.sv ***
/*
 Far-side SPI device model: resolves the three shared pads from the
 block's drivers and its own. Assumes pull-ups on every pad.
*/
module spi_far_end (
   // Far-side drive requests, index 0 cotin, 1 citout, 2 select
   input wire logic [2:0] i_far_en,
   input wire logic [2:0] i_far_lvl,
   // Block pad controls
   input wire logic [2:0] i_dev_out,
   input wire logic [2:0] i_dev_oe_n,
   input wire logic [2:0] i_dev_spi,
   // Resolved pad levels
   output logic [2:0] o_pad
);
   // Block driver wins, then far side, then the pull-up; an idle pad
   // never keeps a stale level
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (!i_dev_oe_n[i] && i_dev_spi[i]) begin
            o_pad[i] = i_dev_out[i];
         end else if (i_far_en[i]) begin
            o_pad[i] = i_far_lvl[i];
         end else begin
            o_pad[i] = 1'b1;
         end
      end
   end
endmodule : spi_far_end

// *** tb/spi_pin_mode_and_baud_control_tb.sv ***
/*
 Testbench of the SPI pin-mode and bit-rate block: APB register tasks,
 pad steering tables, wait gating and bit period measurement.
 Assumes the design files and constants header are compiled first.
*/
`include "spi_pin_baud_regs.svh"
module spi_pin_mode_and_baud_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, wait_mode, ser_out, sel_out;
   logic pready, pslverr, err, ser_in, sel_in_n, fault_in_n, clk_run;
   logic bit_tick, bit_clk, ctl_sel;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [2:0] far_en, far_lvl, pad, d_out, d_oe_n, d_spi;
   int miscompares, n_checks, cycles, cnt;

   // Clock of 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   spi_pin_baud_ctrl DUT (
      .i_core_clk(clk), .i_arst_n(rst_n),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_wait_mode(wait_mode), .i_ser_out(ser_out),
      .i_sel_out(sel_out), .o_ser_in(ser_in), .o_sel_in_n(sel_in_n),
      .o_mode_fault_in_n(fault_in_n), .o_clk_run(clk_run), .o_bit_tick(bit_tick),
      .o_bit_clk(bit_clk), .o_controller_select(ctl_sel),
      .i_cotin_pad(pad[0]), .o_cotin_out(d_out[0]), .o_cotin_oe_n(d_oe_n[0]),
      .o_cotin_spi(d_spi[0]), .i_citout_pad(pad[1]), .o_citout_out(d_out[1]),
      .o_citout_oe_n(d_oe_n[1]), .o_citout_spi(d_spi[1]), .i_sel_pad(pad[2]),
      .o_sel_out(d_out[2]), .o_sel_oe_n(d_oe_n[2]), .o_sel_spi(d_spi[2]));

   spi_far_end far (.i_far_en(far_en), .i_far_lvl(far_lvl), .i_dev_out(d_out),
      .i_dev_oe_n(d_oe_n), .i_dev_spi(d_spi), .o_pad(pad));

   task automatic close_out();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Bounded wait for the next bit tick, counting cycles
   task automatic next_tick();
      cnt = 0;
      do begin
         @(posedge clk);
         cnt++;
      end while (bit_tick !== 1'b1 && cnt < 3000);
   endtask : next_tick

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles > 40000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      {psel, penable, pwrite, wait_mode, ser_out, sel_out} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h1;
      far_en = '0;
      far_lvl = '0;
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and reserved bits
      chk({d_oe_n, clk_run, bit_tick}, {3'b101, 1'b1, 1'b0});
      apb(0, `CTRL_TWO_OFFSET, 0); chk(rd, `CTRL_TWO_RESET);
      apb(0, `BIT_RATE_OFFSET, 0); chk(rd, `BIT_RATE_RESET);
      apb(1, `CTRL_TWO_OFFSET, 32'hffff_ffff);
      apb(0, `CTRL_TWO_OFFSET, 0); chk(rd, 32'h0000_001b);
      apb(1, `BIT_RATE_OFFSET, 32'hffff_ffff);
      apb(0, `BIT_RATE_OFFSET, 0); chk(rd, 32'h0000_0077);
      pstrb <= 4'h0;
      apb(1, `BIT_RATE_OFFSET, 32'h0000_0011);
      pstrb <= 4'h1;
      apb(0, `BIT_RATE_OFFSET, 0); chk(rd, 32'h0000_0077);
      apb(1, 12'h010, 32'h5);
      chk(err, 1'b1);
      apb(0, 12'h010, 0); chk({err, rd}, {1'b1, 32'h0});
      // Select pad role for every mode, fault enable and drive enable
      for (int k = 0; k < 8; k++) begin
         apb(1, `MODE_CTRL_OFFSET, {30'h0, k[1], k[2]});
         apb(1, `CTRL_TWO_OFFSET, {27'h0, k[0], 4'h0});
         sel_out <= k[0];
         @(posedge clk);
         chk(ctl_sel, k[2]);
         chk(d_spi[2], !k[2] || k[0]);
         if (d_spi[2] === 1'b1) begin
            chk(d_oe_n[2], !(k[2] && k[0] && k[1]));
         end
         if (d_oe_n[2] === 1'b0) begin
            chk(d_out[2], k[0]);
         end
      end
      // Data pad steering in all modes
      for (int k = 0; k < 8; k++) begin
         apb(1, `MODE_CTRL_OFFSET, {31'h0, k[2]});
         apb(1, `CTRL_TWO_OFFSET, {28'h0, k[1], 2'b00, k[0]});
         ser_out <= k[1];
         @(posedge clk);
         chk(d_spi[1:0], {!(k[0] && k[2]), !(k[0] && !k[2])});
         if (k[2]) begin
            chk(d_oe_n[0], k[0] ? !k[1] : 1'b0);
            chk(d_out[0], k[1]);
         end else begin
            chk(d_oe_n[1], k[0] ? !k[1] : 1'b0);
            if (!k[0]) chk(d_oe_n[0], 1'b1);
         end
      end
      // Serial input path: four-wire controller, then single-wire controller
      for (int k = 0; k < 4; k++) begin
         apb(1, `CTRL_TWO_OFFSET, {31'h0, k[1]});
         far_en <= k[1] ? 3'b001 : 3'b010;
         far_lvl <= {3{k[0]}};
         repeat (5) @(posedge clk);
         chk(ser_in, k[0]);
      end
      // Fault input in controller mode, target select input in target mode
      far_en <= 3'b100;
      far_lvl <= 3'b000;
      apb(1, `MODE_CTRL_OFFSET, 32'h1);
      apb(1, `CTRL_TWO_OFFSET, 32'h10);
      repeat (5) @(posedge clk);
      chk({fault_in_n, sel_in_n}, 2'b01);
      apb(1, `MODE_CTRL_OFFSET, 32'h0);
      repeat (5) @(posedge clk);
      chk({fault_in_n, sel_in_n}, 2'b10);
      // Bit period for four prescale and rate field pairs, written mid-run
      apb(1, `MODE_CTRL_OFFSET, 32'h1);
      apb(1, `CTRL_TWO_OFFSET, 32'h0);
      for (int k = 0; k < 4; k++) begin
         apb(1, `BIT_RATE_OFFSET, {25'h0, 3'(k * 7 % 8), 1'b0, 3'(k * 3 % 8)});
         next_tick();
         next_tick();
         next_tick();
         chk(cnt, ((k * 7 % 8) + 1) << ((k * 3 % 8) + 1));
      end
      // Wait gating: clocks stop only with halt enabled
      apb(1, `BIT_RATE_OFFSET, 32'h0);
      for (int k = 0; k < 4; k++) begin
         apb(1, `CTRL_TWO_OFFSET, {30'h0, k[1], 1'b0});
         wait_mode <= k[0];
         @(posedge clk);
         @(posedge clk);
         chk(clk_run, !(k[0] && k[1]));
      end
      rd[0] = bit_clk;
      next_tick();
      chk(cnt, 3000);
      chk(bit_clk, rd[0]);
      wait_mode <= 1'b0;
      // Target mode freezes the divider
      apb(1, `MODE_CTRL_OFFSET, 32'h0);
      @(posedge clk);
      next_tick();
      chk(cnt, 3000);
      close_out();
   end
endmodule : spi_pin_mode_and_baud_control_tb
